/* rtl/tait_pkg.sv */
// Constants, offsets and field positions of the interval timer
package tait_pkg;
    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam logic [7:0]  OFF_CONTROL    = 8'h00;
    localparam logic [7:0]  OFF_COUNT      = 8'h10;
    localparam logic [7:0]  OFF_PERIOD     = 8'h20;
    localparam logic [7:0]  OFF_STATUS     = 8'h30;
    localparam logic [7:0]  OFF_MASK       = 8'h34;
    localparam logic [1:0]  ALIAS_WRITE    = 2'h0;
    localparam logic [1:0]  ALIAS_CLEAR    = 2'h1;
    localparam logic [1:0]  ALIAS_SET      = 2'h2;
    localparam logic [1:0]  ALIAS_INVERT   = 2'h3;
    localparam int unsigned BIT_ON         = 15;
    localparam int unsigned BIT_STOP_IDLE  = 13;
    localparam int unsigned BIT_WR_BLOCK   = 12;
    localparam int unsigned BIT_WR_PENDING = 11;
    localparam int unsigned BIT_GATE_EN    = 7;
    localparam int unsigned BIT_PRESC_HI   = 5;
    localparam int unsigned BIT_PRESC_LO   = 4;
    localparam int unsigned BIT_SYNC_SEL   = 2;
    localparam int unsigned BIT_CLK_SRC    = 1;
    localparam int unsigned BIT_EV_TIMER   = 0;
    localparam logic [15:0] CTRL_WR_MASK   = 16'hb0b6;
    localparam logic [15:0] CTRL_RST       = 16'h0000;
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    localparam logic [15:0] PERIOD_RST     = 16'hffff;
    localparam logic [0:0]  STATUS_RST     = 1'h0;
    localparam logic [0:0]  MASK_RST       = 1'h0;
    localparam logic [1:0]  PRESC_1        = 2'h0;
    localparam logic [1:0]  PRESC_8        = 2'h1;
    localparam logic [1:0]  PRESC_64       = 2'h2;
    localparam logic [1:0]  PRESC_256      = 2'h3;
    localparam logic [7:0]  PRESC_MAX_1    = 8'h00;
    localparam logic [7:0]  PRESC_MAX_8    = 8'h07;
    localparam logic [7:0]  PRESC_MAX_64   = 8'h3f;
    localparam logic [7:0]  PRESC_MAX_256  = 8'hff;
endpackage

/* rtl/tait_top.sv */
// Sixteen-bit interval timer and event counter with register port
//
// Functional notes
// - One 16-bit counter, timer or event counter
// - Internal, gated, sync external, async external modes
// - Control bit 15 enables the timer
// - Bit 13 stops timer during Idle
// - Bit 12 blocks count writes while pending
// - Bit 11 shows async write pending, sync zero
// - Bit 7 gates internal clock only
// - Bits 5-4 prescale 1, 8, 64, 256
// - Bit 2 synchronizes external clock when external
// - Bit 1 selects external pin or internal
// - Unimplemented control bits read zero, ignore writes
// - Clear, set, invert aliases touch ones only
// - Timer may run in Idle and Sleep
// - Async external mode counts secondary oscillator
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tait_top (
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output var  logic [31:0] REG_RDATA,
    input  wire logic        EXT_CLOCK_PIN,
    input  wire logic        GATE_IN,
    input  wire logic        CPU_IDLE,
    input  wire logic        CPU_SLEEP,
    output var  logic        TIMER_IRQ
);

    function automatic logic [15:0] alias_apply(input logic [15:0] old,
                                                input logic [15:0] wd,
                                                input logic [1:0]  kind);
        case (kind)
            tait_pkg::ALIAS_WRITE:  alias_apply = wd;
            tait_pkg::ALIAS_CLEAR:  alias_apply = old & ~wd;
            tait_pkg::ALIAS_SET:    alias_apply = old | wd;
            tait_pkg::ALIAS_INVERT: alias_apply = old ^ wd;
            default:                alias_apply = old;
        endcase
    endfunction

    function automatic logic [7:0] presc_max(input logic [1:0] sel);
        case (sel)
            tait_pkg::PRESC_1:   presc_max = tait_pkg::PRESC_MAX_1;
            tait_pkg::PRESC_8:   presc_max = tait_pkg::PRESC_MAX_8;
            tait_pkg::PRESC_64:  presc_max = tait_pkg::PRESC_MAX_64;
            tait_pkg::PRESC_256: presc_max = tait_pkg::PRESC_MAX_256;
            default:             presc_max = tait_pkg::PRESC_MAX_1;
        endcase
    endfunction

    logic [15:0] ctrl_q;
    logic [15:0] count_q;
    logic [15:0] period_q;
    logic [15:0] pend_val_q;
    logic        pend_q;
    logic [7:0]  presc_q;
    logic [0:0]  status_q;
    logic [0:0]  mask_q;
    logic        ext_s1_q;
    logic        ext_s2_q;
    logic        ext_s3_q;
    logic        ext_raw_q;
    logic        gate_q;

    logic [1:0]  alias_kind;
    logic [7:0]  base_addr;
    logic        wr_ctrl;
    logic        wr_count;
    logic        wr_period;
    logic        wr_status;
    logic        wr_mask;
    logic        ctrl_on;
    logic        ctrl_stop_in_idle;
    logic        ctrl_block;
    logic        ctrl_gate;
    logic        ctrl_sync;
    logic        ctrl_ext;
    logic [1:0]  ctrl_presc;
    logic        async_mode;
    logic        gated_mode;
    logic        ext_rise_sync;
    logic        ext_rise_raw;
    logic        base_tick;
    logic        run;
    logic        tick;
    logic        period_hit;
    logic        gate_fall;
    logic        ev_timer;
    logic        wr_pending_rd;
    logic [15:0] count_wval;
    logic        count_take_sync;
    logic        count_take_async;
    logic        pend_apply;
    logic [0:0]  status_d;

    assign alias_kind = REG_ADDR[3:2];
    assign base_addr  = {REG_ADDR[7:4], 4'h0};
    assign wr_ctrl    = REG_WR && (base_addr == tait_pkg::OFF_CONTROL);
    assign wr_count   = REG_WR && (base_addr == tait_pkg::OFF_COUNT);
    assign wr_period  = REG_WR && (base_addr == tait_pkg::OFF_PERIOD);
    assign wr_status  = REG_WR && (REG_ADDR == tait_pkg::OFF_STATUS);
    assign wr_mask    = REG_WR && (REG_ADDR == tait_pkg::OFF_MASK);

    assign ctrl_on    = ctrl_q[tait_pkg::BIT_ON];
    assign ctrl_stop_in_idle  = ctrl_q[tait_pkg::BIT_STOP_IDLE];
    assign ctrl_block = ctrl_q[tait_pkg::BIT_WR_BLOCK];
    assign ctrl_gate  = ctrl_q[tait_pkg::BIT_GATE_EN];
    assign ctrl_sync  = ctrl_q[tait_pkg::BIT_SYNC_SEL];
    assign ctrl_ext   = ctrl_q[tait_pkg::BIT_CLK_SRC];
    assign ctrl_presc = ctrl_q[tait_pkg::BIT_PRESC_HI:tait_pkg::BIT_PRESC_LO];

    // Mode decode; gate enable means nothing on the external pin
    assign async_mode = ctrl_ext && !ctrl_sync;
    assign gated_mode = !ctrl_ext && ctrl_gate;

    // Synchronized edge costs two cycles of latency but is glitch safe
    assign ext_rise_sync = ext_s2_q && !ext_s3_q;
    // Raw edge follows the pin directly, used when sync is off
    assign ext_rise_raw  = EXT_CLOCK_PIN && !ext_raw_q;

    always_comb begin
        if (ctrl_ext) begin
            base_tick = ctrl_sync ? ext_rise_sync : ext_rise_raw;
        end else if (ctrl_gate) begin
            base_tick = GATE_IN;
        end else begin
            base_tick = 1'b1;
        end
    end

    // Only the async external path keeps counting in Sleep
    assign run = ctrl_on
              && !(CPU_IDLE && ctrl_stop_in_idle)
              && !(CPU_SLEEP && !async_mode);

    assign tick       = run && base_tick && (presc_q == presc_max(ctrl_presc));
    assign period_hit = tick && (count_q == period_q);
    assign gate_fall  = ctrl_on && gated_mode && gate_q && !GATE_IN;
    assign ev_timer   = gated_mode ? gate_fall : period_hit;

    assign wr_pending_rd = pend_q && async_mode;

    assign count_wval       = alias_apply(count_q, REG_WDATA[15:0], alias_kind);
    assign count_take_sync  = wr_count && !async_mode;
    assign count_take_async = wr_count && async_mode && !(pend_q && ctrl_block);
    // Pending value lands on the next pin edge, or at once if mode left async
    assign pend_apply       = pend_q && (!async_mode || ext_rise_raw);

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ext_s1_q  <= 1'b0;
            ext_s2_q  <= 1'b0;
            ext_s3_q  <= 1'b0;
            ext_raw_q <= 1'b0;
            gate_q    <= 1'b0;
        end else begin
            ext_s1_q  <= EXT_CLOCK_PIN;
            ext_s2_q  <= ext_s1_q;
            ext_s3_q  <= ext_s2_q;
            ext_raw_q <= EXT_CLOCK_PIN;
            gate_q    <= GATE_IN;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_q <= tait_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= alias_apply(ctrl_q, REG_WDATA[15:0], alias_kind)
                    & tait_pkg::CTRL_WR_MASK;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            period_q <= tait_pkg::PERIOD_RST;
        end else if (wr_period) begin
            period_q <= alias_apply(period_q, REG_WDATA[15:0], alias_kind);
        end
    end

    // Prescaler restarts when off or when the count is loaded
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            presc_q <= 8'h00;
        end else if (!ctrl_on || count_take_sync || pend_apply) begin
            presc_q <= 8'h00;
        end else if (run && base_tick) begin
            if (presc_q >= presc_max(ctrl_presc)) begin
                presc_q <= 8'h00;
            end else begin
                presc_q <= presc_q + 8'h01;
            end
        end
    end

    // Async write slot; without the block a new write overwrites the old
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            pend_q     <= 1'b0;
            pend_val_q <= tait_pkg::COUNT_RST;
        end else if (count_take_async) begin
            pend_q     <= 1'b1;
            pend_val_q <= count_wval;
        end else if (pend_apply) begin
            pend_q     <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            count_q <= tait_pkg::COUNT_RST;
        end else if (count_take_sync) begin
            count_q <= count_wval;
        end else if (pend_apply) begin
            count_q <= pend_val_q;
        end else if (period_hit) begin
            count_q <= 16'h0000;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // Set beats a write-one clear landing in the same cycle
    always_comb begin
        status_d = status_q;
        if (wr_status && REG_WDATA[tait_pkg::BIT_EV_TIMER]) begin
            status_d[tait_pkg::BIT_EV_TIMER] = 1'b0;
        end
        if (ev_timer) begin
            status_d[tait_pkg::BIT_EV_TIMER] = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            status_q <= tait_pkg::STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            mask_q <= tait_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_q <= REG_WDATA[tait_pkg::BIT_EV_TIMER:tait_pkg::BIT_EV_TIMER];
        end
    end

    // Registered from next status so the level follows the flag
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            TIMER_IRQ <= 1'b0;
        end else begin
            TIMER_IRQ <= |(status_d & mask_q);
        end
    end

    // Aliases read back the base register; unmapped reads give zero
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            if (base_addr == tait_pkg::OFF_CONTROL) begin
                REG_RDATA <= {16'h0000, ctrl_q | {4'h0, wr_pending_rd, 11'h000}};
            end else if (base_addr == tait_pkg::OFF_COUNT) begin
                REG_RDATA <= {16'h0000, count_q};
            end else if (base_addr == tait_pkg::OFF_PERIOD) begin
                REG_RDATA <= {16'h0000, period_q};
            end else if (REG_ADDR == tait_pkg::OFF_STATUS) begin
                REG_RDATA <= {31'h0000_0000, status_q};
            end else if (REG_ADDR == tait_pkg::OFF_MASK) begin
                REG_RDATA <= {31'h0000_0000, mask_q};
            end else begin
                REG_RDATA <= 32'h0000_0000;
            end
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

/* verification/tait_checker.sv */
// Port-level assertions for the interval timer
`timescale 1ns/1ps
`default_nettype none
module tait_checker (
    input wire logic        CLK_SYS,
    input wire logic        SYS_RST,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic        EXT_CLOCK_PIN,
    input wire logic        GATE_IN,
    input wire logic        CPU_IDLE,
    input wire logic        CPU_SLEEP,
    input wire logic        TIMER_IRQ
);
    logic [15:0] ctrl_q;
    logic [15:0] per_q;
    logic        mask_q;
    function automatic logic [15:0] upd(input logic [15:0] o, input logic [15:0] w,
                                        input logic [1:0] k);
        case (k)
            tait_pkg::ALIAS_CLEAR:  return o & ~w;
            tait_pkg::ALIAS_SET:    return o | w;
            tait_pkg::ALIAS_INVERT: return o ^ w;
            default:                return w;
        endcase
    endfunction
    // Shadow of control, period and mask, updated on the same edge as the block
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_q <= tait_pkg::CTRL_RST;
            per_q  <= tait_pkg::PERIOD_RST;
            mask_q <= 1'b0;
        end else if (REG_WR && REG_ADDR[1:0] == 2'h0) begin
            if (REG_ADDR[7:4] == 4'h0)
                ctrl_q <= upd(ctrl_q, REG_WDATA[15:0], REG_ADDR[3:2]) & tait_pkg::CTRL_WR_MASK;
            if (REG_ADDR[7:4] == 4'h2)
                per_q <= upd(per_q, REG_WDATA[15:0], REG_ADDR[3:2]);
            if (REG_ADDR == tait_pkg::OFF_MASK)
                mask_q <= REG_WDATA[0];
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data not zero outside answer cycle");
    chk_upper_zero: assert property ($past(REG_RD) |-> REG_RDATA[31:16] == 16'h0)
        else $error("upper read half not zero");
    chk_ctrl_read: assert property ($past(REG_RD && REG_ADDR[7:4] == 4'h0 && REG_ADDR[1:0] == 2'h0)
        |-> (REG_RDATA & 32'hfffff7ff) == {16'h0, $past(ctrl_q)}) else $error("control readback");
    chk_pend_sync: assert property ($past(REG_RD && REG_ADDR == 8'h00
        && !(ctrl_q[1] && !ctrl_q[2])) |-> !REG_RDATA[11]) else $error("pending set in sync mode");
    chk_period_read: assert property ($past(REG_RD && REG_ADDR[7:4] == 4'h2 && REG_ADDR[1:0] == 2'h0)
        |-> REG_RDATA == {16'h0, $past(per_q)}) else $error("period readback");
    chk_mask_read: assert property ($past(REG_RD && REG_ADDR == 8'h34)
        |-> REG_RDATA == {31'h0, $past(mask_q)}) else $error("mask readback");
    chk_status_width: assert property ($past(REG_RD && REG_ADDR == 8'h30)
        |-> REG_RDATA[31:1] == 31'h0) else $error("status wider than one bit");
    chk_unmapped_zero: assert property ($past(REG_RD && REG_ADDR[7:6] != 2'h0)
        |-> REG_RDATA == 32'h0) else $error("unmapped read not zero");
    chk_irq_masked: assert property (!mask_q && !$past(mask_q) |-> !TIMER_IRQ)
        else $error("interrupt while masked");
    cover property ($rose(TIMER_IRQ));
    cover property (REG_WR && REG_ADDR == 8'h0c);
    cover property (REG_RD && REG_ADDR == 8'h10 && ctrl_q[15]);
endmodule
bind tait_top tait_checker i_tait_checker (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .EXT_CLOCK_PIN(EXT_CLOCK_PIN), .GATE_IN(GATE_IN),
    .CPU_IDLE(CPU_IDLE), .CPU_SLEEP(CPU_SLEEP), .TIMER_IRQ(TIMER_IRQ));
`default_nettype wire

/* verification/tait_ext_src.sv */
// External clock source driving the timer pin
`timescale 1ns/1ps
`default_nettype none
module tait_ext_src (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [3:0] half,
    output var  logic       pin
);
    logic [3:0] cnt_q;
    // Stands low between bursts, so no stray edge reaches the timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            pin   <= 1'b0;
        end else if (!run) begin
            cnt_q <= 4'h0;
            pin   <= 1'b0;
        end else if (cnt_q == half) begin
            cnt_q <= 4'h0;
            pin   <= ~pin;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* verification/tait_top_test.sv */
// Self-checking bench for the interval timer
`timescale 1ns/1ps
`default_nettype none
module tait_top_test;
    logic        CLK_SYS, SYS_RST, REG_WR, REG_RD, GATE_IN, CPU_IDLE, CPU_SLEEP;
    logic        EXT_CLOCK_PIN, TIMER_IRQ, ext_run;
    logic [7:0]  REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, d, c;
    int          errors, checks_done, n, n0;
    int          div [4] = '{1, 8, 64, 256};
    logic [39:0] rv [5] = '{{8'h00, 32'h0}, {8'h10, 32'h0}, {8'h20, 32'hffff},
                            {8'h30, 32'h0}, {8'h34, 32'h0}};
    logic [79:0] tbl [10] = '{{8'h00, 32'hffffffff, 8'h00, 32'hb0b6},
                              {8'h04, 32'h00000030, 8'h00, 32'hb086},
                              {8'h08, 32'h00000020, 8'h00, 32'hb0a6},
                              {8'h0c, 32'h0000a000, 8'h00, 32'h10a6},
                              {8'h00, 32'h00000000, 8'h00, 32'h0},
                              {8'h20, 32'h12345678, 8'h24, 32'h5678},
                              {8'h2c, 32'h0000ffff, 8'h20, 32'ha987},
                              {8'h34, 32'h00000003, 8'h34, 32'h1},
                              {8'h40, 32'hffffffff, 8'h40, 32'h0},
                              {8'h34, 32'h00000000, 8'h34, 32'h0}};
    tait_top i_tait_top (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .EXT_CLOCK_PIN(EXT_CLOCK_PIN), .GATE_IN(GATE_IN), .CPU_IDLE(CPU_IDLE),
        .CPU_SLEEP(CPU_SLEEP), .TIMER_IRQ(TIMER_IRQ));
    tait_ext_src i_tait_ext_src (.clk(CLK_SYS), .rst(SYS_RST), .run(ext_run),
        .half(4'h2), .pin(EXT_CLOCK_PIN));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One idle cycle after every write keeps clear of the just-disabled hazard
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WR <= 1'b1;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        #1 v = REG_RDATA;
        @(posedge CLK_SYS);
    endtask
    task automatic finish_test();
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        errors++;
        finish_test();
    end
    initial begin
        SYS_RST = 1'b1; REG_WR = 1'b0; REG_RD = 1'b0; REG_ADDR = 8'h0; REG_WDATA = 32'h0;
        GATE_IN = 1'b0; CPU_IDLE = 1'b0; CPU_SLEEP = 1'b0; ext_run = 1'b0;
        errors = 0; checks_done = 0;
        repeat (12) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        @(posedge CLK_SYS);
        foreach (tbl[i]) begin
            wr(tbl[i][79:72], tbl[i][71:40]);
            rd(tbl[i][39:32], d);
            chk(d, tbl[i][31:0]);
        end
        // Fixed latency cancels out: only the spread between divisors is compared
        wr(8'h20, 32'h4);
        wr(8'h34, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, 32'h0); wr(8'h30, 32'h1); wr(8'h10, 32'h0);
            wr(8'h00, 32'h8000 | (k << 4));
            n = 0;
            while (TIMER_IRQ !== 1'b1 && n < 2000) begin
                @(posedge CLK_SYS);
                #1 n++;
            end
            @(posedge CLK_SYS);
            if (k == 0) n0 = n;
            chk(n - n0, 5 * (div[k] - 1));
        end
        wr(8'h00, 32'h0);
        rd(8'h30, d); chk(d, 32'h1);
        wr(8'h30, 32'h1);
        rd(8'h30, d); chk(d, 32'h0);
        chk({31'h0, TIMER_IRQ}, 32'h0);
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        @(posedge CLK_SYS);
        foreach (rv[i]) begin
            rd(rv[i][39:32], d); chk(d, rv[i][31:0]);
        end
        CPU_IDLE <= 1'b1;
        wr(8'h00, 32'ha000);
        rd(8'h10, c); repeat (10) @(posedge CLK_SYS); rd(8'h10, d);
        chk(d, c);
        wr(8'h00, 32'h8000);
        rd(8'h10, d); chk({31'h0, d != c}, 32'h1);
        CPU_IDLE <= 1'b0;
        wr(8'h00, 32'h0); wr(8'h10, 32'h0); wr(8'h00, 32'h8080);
        GATE_IN <= 1'b1;
        repeat (6) @(posedge CLK_SYS);
        GATE_IN <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        rd(8'h30, d); chk(d, 32'h1);
        rd(8'h10, d); chk(d, 32'h6);
        wr(8'h00, 32'h9002); wr(8'h10, 32'h100);
        rd(8'h00, d); chk(d & 32'h800, 32'h800);
        wr(8'h10, 32'h200);
        CPU_SLEEP <= 1'b1; ext_run <= 1'b1;
        repeat (60) @(posedge CLK_SYS);
        CPU_SLEEP <= 1'b0; ext_run <= 1'b0;
        rd(8'h10, d); chk(d & 32'hff00, 32'h100);
        chk({31'h0, d[7:0] != 8'h0}, 32'h1);
        rd(8'h00, d); chk(d & 32'h800, 32'h0);
        wr(8'h00, 32'h8086); wr(8'h10, 32'h0);
        ext_run <= 1'b1;
        repeat (60) @(posedge CLK_SYS);
        ext_run <= 1'b0;
        rd(8'h10, d); chk({31'h0, d[15:0] != 16'h0}, 32'h1);
        wr(8'h00, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
